/* File: rtl/btg_pkg.sv */
// Constants of the beep tone generator: register offsets, fields, resets.
// Assumes an 8-bit register port with 7-bit offsets.
package btg_pkg;
  localparam int          BTG_ADDR_W      = 7;
  localparam int          BTG_DATA_W      = 8;
  localparam int          BTG_LVL_W       = 6;
  localparam int          BTG_LEN_W       = 24;
  localparam int          BTG_SMP_W       = 16;
  localparam int          BTG_OSC_FRAC    = 15;
  localparam int          BTG_GAIN_FRAC   = 14;
  localparam int          BTG_DB_STEPS    = 6;

  localparam logic [6:0]  BTG_OFS_LEFT    = 7'h47;
  localparam logic [6:0]  BTG_OFS_RIGHT   = 7'h48;
  localparam logic [6:0]  BTG_OFS_LEN_H   = 7'h49;
  localparam logic [6:0]  BTG_OFS_LEN_M   = 7'h4a;
  localparam logic [6:0]  BTG_OFS_LEN_L   = 7'h4b;
  localparam logic [6:0]  BTG_OFS_SIN_H   = 7'h4c;
  localparam logic [6:0]  BTG_OFS_SIN_L   = 7'h4d;
  localparam logic [6:0]  BTG_OFS_COS_H   = 7'h4e;
  localparam logic [6:0]  BTG_OFS_COS_L   = 7'h4f;
  localparam logic [6:0]  BTG_OFS_RSVD    = 7'h50;

  localparam int          BTG_EN_BIT      = 7;
  localparam int          BTG_LVL_MSB     = 5;
  localparam int          BTG_LINK_MSB    = 7;
  localparam int          BTG_LINK_LSB    = 6;
  localparam logic [1:0]  BTG_LINK_R2L    = 2'h1;
  localparam logic [1:0]  BTG_LINK_L2R    = 2'h2;

  localparam logic [7:0]  BTG_RST_CTL     = 8'h00;
  localparam logic [7:0]  BTG_RST_LEN_H   = 8'h00;
  localparam logic [7:0]  BTG_RST_LEN_M   = 8'h00;
  localparam logic [7:0]  BTG_RST_LEN_L   = 8'hee;
  localparam logic [7:0]  BTG_RST_SIN_H   = 8'h10;
  localparam logic [7:0]  BTG_RST_SIN_L   = 8'hd8;
  localparam logic [7:0]  BTG_RST_COS_H   = 8'h7e;
  localparam logic [7:0]  BTG_RST_COS_L   = 8'he3;
  localparam logic [7:0]  BTG_RST_RSVD    = 8'h00;

  localparam logic [15:0] BTG_OSC_START   = 16'h7fff;
  localparam logic [15:0] BTG_GAIN_P2DB   = 16'h5092;
  localparam logic [15:0] BTG_GAIN_P1DB   = 16'h47cf;
  localparam logic [15:0] BTG_GAIN_0DB    = 16'h4000;
  localparam logic [15:0] BTG_GAIN_M1DB   = 16'h390a;
  localparam logic [15:0] BTG_GAIN_M2DB   = 16'h32d6;
  localparam logic [15:0] BTG_GAIN_M3DB   = 16'h2d4f;

  typedef enum logic {
    BTG_IDLE = 1'b0,
    BTG_RUN  = 1'b1
  } btg_state_t;
endpackage

/* File: rtl/btg_gain_rom.sv */
// Level code to linear gain table, registered read data.
// Assumes the code is held stable for at least one clock before use.
`timescale 1ns/100ps
module btg_gain_rom (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic [btg_pkg::BTG_LVL_W-1:0] code_i,
  output logic      [15:0]               gain_o
);
  import btg_pkg::*;

  logic [15:0] gain_reg;
  logic [15:0] gain_next;
  logic [15:0] mant;
  logic [3:0]  shift;

  assign gain_o = gain_reg;

  // Each code is 1 dB down; six codes make one halving of the gain.
  always_comb begin
    shift = 4'(code_i / BTG_DB_STEPS);
    case (code_i % BTG_DB_STEPS)
      6'd0:    mant = BTG_GAIN_P2DB;
      6'd1:    mant = BTG_GAIN_P1DB;
      6'd2:    mant = BTG_GAIN_0DB;
      6'd3:    mant = BTG_GAIN_M1DB;
      6'd4:    mant = BTG_GAIN_M2DB;
      default: mant = BTG_GAIN_M3DB;
    endcase
    gain_next = mant >> shift;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      gain_reg <= 16'h0000;
    end else begin
      gain_reg <= gain_next;
    end
  end
endmodule

/* File: rtl/btg_core.sv */
// Beep tone generator of the DAC playback path: registers and oscillator.
// Assumes sample_tick_i pulses once per DAC word clock, synchronous input.
// Operation
// - Enable starts tone, clears itself after length
// - Left level: code 0 is +2 dB
// - Right level uses the same dB mapping
// - Link 00 or 11: independent levels
// - Link 01: left follows right level
// - Link 10: right follows left level
// - Length is 24-bit sample count, three bytes
// - Length resets to 238 samples
// - Sine coefficient 16 bits, reset 0x10d8
// - Cosine coefficient 16 bits, reset 0x7ee3
`timescale 1ns/100ps
module btg_core (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  input  wire logic [btg_pkg::BTG_ADDR_W-1:0] reg_addr_i,
  input  wire logic [btg_pkg::BTG_DATA_W-1:0] reg_wdata_i,
  input  wire logic                        sample_tick_i,
  input  wire logic                        tone_capable_dac_processing_mode_i,
  output logic      [btg_pkg::BTG_DATA_W-1:0] reg_rdata_o,
  output logic signed [btg_pkg::BTG_SMP_W-1:0] beep_left_o,
  output logic signed [btg_pkg::BTG_SMP_W-1:0] beep_right_o,
  output logic                             beep_valid_o,
  output logic                             beep_active_o
);
  import btg_pkg::*;

  logic [7:0]        left_ctl_reg, left_ctl_next;
  logic [7:0]        right_ctl_reg, right_ctl_next;
  logic [7:0]        len_h_reg, len_h_next, len_m_reg, len_m_next;
  logic [7:0]        len_l_reg, len_l_next;
  logic [7:0]        sin_h_reg, sin_h_next, sin_l_reg, sin_l_next;
  logic [7:0]        cos_h_reg, cos_h_next, cos_l_reg, cos_l_next;
  logic [7:0]        rsvd_reg, rsvd_next, rdata_reg, rdata_next;
  btg_state_t        state_reg, state_next;
  logic [23:0]       remain_reg, remain_next;
  logic signed [15:0] sin_k_reg, sin_k_next, cos_k_reg, cos_k_next;
  logic [5:0]        lvl_l_reg, lvl_l_next, lvl_r_reg, lvl_r_next;
  logic signed [15:0] x_reg, x_next, y_reg, y_next;
  logic signed [15:0] out_l_reg, out_l_next, out_r_reg, out_r_next;
  logic              valid_reg, valid_next;
  logic [23:0]       length;
  logic [1:0]        link;
  logic [5:0]        sel_l, sel_r, rom_l, rom_r;
  logic [15:0]       gain_l, gain_r;

  // Products are summed at full width, then scaled and saturated.
  function automatic logic signed [15:0] btg_mac(
    input logic signed [15:0] a,
    input logic signed [15:0] b,
    input logic signed [15:0] c,
    input logic signed [15:0] d,
    input int                 frac
  );
    logic signed [33:0] acc;
    acc = 34'(a * b) + 34'(c * d);
    acc = acc >>> frac;
    if (acc > 34'sh0_7fff) begin
      return 16'sh7fff;
    end else if (acc < -34'sh0_8000) begin
      return -16'sh8000;
    end
    return acc[15:0];
  endfunction

  assign length = {len_h_reg, len_m_reg, len_l_reg};
  assign link   = right_ctl_reg[BTG_LINK_MSB:BTG_LINK_LSB];

  always_comb begin
    sel_l = left_ctl_reg[BTG_LVL_MSB:0];
    sel_r = right_ctl_reg[BTG_LVL_MSB:0];
    if (link == BTG_LINK_R2L) begin
      sel_l = right_ctl_reg[BTG_LVL_MSB:0];
    end
    if (link == BTG_LINK_L2R) begin
      sel_r = left_ctl_reg[BTG_LVL_MSB:0];
    end
  end

  // While idle the table follows the live levels, so the gain is ready
  // in the first cycle of a beep.
  assign rom_l = (state_reg == BTG_IDLE) ? sel_l : lvl_l_reg;
  assign rom_r = (state_reg == BTG_IDLE) ? sel_r : lvl_r_reg;

  btg_gain_rom u_rom_left (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .code_i    (rom_l),
    .gain_o    (gain_l)
  );

  btg_gain_rom u_rom_right (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .code_i    (rom_r),
    .gain_o    (gain_r)
  );

  always_comb begin
    left_ctl_next  = left_ctl_reg;
    right_ctl_next = right_ctl_reg;
    len_h_next     = len_h_reg;
    len_m_next     = len_m_reg;
    len_l_next     = len_l_reg;
    sin_h_next     = sin_h_reg;
    sin_l_next     = sin_l_reg;
    cos_h_next     = cos_h_reg;
    cos_l_next     = cos_l_reg;
    rsvd_next      = rsvd_reg;
    rdata_next     = rdata_reg;
    state_next     = state_reg;
    remain_next    = remain_reg;
    sin_k_next     = sin_k_reg;
    cos_k_next     = cos_k_reg;
    lvl_l_next     = lvl_l_reg;
    lvl_r_next     = lvl_r_reg;
    x_next         = x_reg;
    y_next         = y_reg;
    out_l_next     = out_l_reg;
    out_r_next     = out_r_reg;
    valid_next     = 1'b0;
    case (state_reg)
      BTG_IDLE: begin
        out_l_next = 16'sh0000;
        out_r_next = 16'sh0000;
        if (left_ctl_reg[BTG_EN_BIT]) begin
          state_next  = BTG_RUN;
          remain_next = length;
          sin_k_next  = {sin_h_reg, sin_l_reg};
          cos_k_next  = {cos_h_reg, cos_l_reg};
          lvl_l_next  = sel_l;
          lvl_r_next  = sel_r;
          x_next      = BTG_OSC_START;
          y_next      = 16'sh0000;
        end
      end
      BTG_RUN: begin
        if (!left_ctl_reg[BTG_EN_BIT]) begin
          state_next = BTG_IDLE;
        end else if (remain_reg == 24'h000000) begin
          left_ctl_next[BTG_EN_BIT] = 1'b0;
          state_next                = BTG_IDLE;
        end else if (sample_tick_i) begin
          valid_next = 1'b1;
          if (tone_capable_dac_processing_mode_i) begin
            x_next      = btg_mac(cos_k_reg, x_reg, -sin_k_reg, y_reg,
                                  BTG_OSC_FRAC);
            y_next      = btg_mac(sin_k_reg, x_reg, cos_k_reg, y_reg,
                                  BTG_OSC_FRAC);
            out_l_next  = btg_mac(y_reg, $signed({1'b0, gain_l[14:0]}),
                                  16'sh0000, 16'sh0000, BTG_GAIN_FRAC);
            out_r_next  = btg_mac(y_reg, $signed({1'b0, gain_r[14:0]}),
                                  16'sh0000, 16'sh0000, BTG_GAIN_FRAC);
            remain_next = remain_reg - 24'h000001;
            if (remain_reg == 24'h000001) begin
              left_ctl_next[BTG_EN_BIT] = 1'b0;
              state_next                = BTG_IDLE;
            end
          end else begin
            out_l_next = 16'sh0000;
            out_r_next = 16'sh0000;
          end
        end
      end
      default: state_next = BTG_IDLE;
    endcase
    // A register write comes last, so a start beats a self-clear.
    if (reg_wr_i) begin
      case (reg_addr_i)
        BTG_OFS_LEFT:  left_ctl_next  = reg_wdata_i;
        BTG_OFS_RIGHT: right_ctl_next = reg_wdata_i;
        BTG_OFS_LEN_H: len_h_next     = reg_wdata_i;
        BTG_OFS_LEN_M: len_m_next     = reg_wdata_i;
        BTG_OFS_LEN_L: len_l_next     = reg_wdata_i;
        BTG_OFS_SIN_H: sin_h_next     = reg_wdata_i;
        BTG_OFS_SIN_L: sin_l_next     = reg_wdata_i;
        BTG_OFS_COS_H: cos_h_next     = reg_wdata_i;
        BTG_OFS_COS_L: cos_l_next     = reg_wdata_i;
        BTG_OFS_RSVD:  rsvd_next      = reg_wdata_i;
        default:       rsvd_next      = rsvd_reg;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        BTG_OFS_LEFT:  rdata_next = left_ctl_reg;
        BTG_OFS_RIGHT: rdata_next = right_ctl_reg;
        BTG_OFS_LEN_H: rdata_next = len_h_reg;
        BTG_OFS_LEN_M: rdata_next = len_m_reg;
        BTG_OFS_LEN_L: rdata_next = len_l_reg;
        BTG_OFS_SIN_H: rdata_next = sin_h_reg;
        BTG_OFS_SIN_L: rdata_next = sin_l_reg;
        BTG_OFS_COS_H: rdata_next = cos_h_reg;
        BTG_OFS_COS_L: rdata_next = cos_l_reg;
        BTG_OFS_RSVD:  rdata_next = rsvd_reg;
        default:       rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      left_ctl_reg  <= BTG_RST_CTL;
      right_ctl_reg <= BTG_RST_CTL;
      len_h_reg     <= BTG_RST_LEN_H;
      len_m_reg     <= BTG_RST_LEN_M;
      len_l_reg     <= BTG_RST_LEN_L;
      sin_h_reg     <= BTG_RST_SIN_H;
      sin_l_reg     <= BTG_RST_SIN_L;
      cos_h_reg     <= BTG_RST_COS_H;
      cos_l_reg     <= BTG_RST_COS_L;
      rsvd_reg      <= BTG_RST_RSVD;
      rdata_reg     <= 8'h00;
      state_reg     <= BTG_IDLE;
      remain_reg    <= 24'h000000;
      sin_k_reg     <= 16'sh0000;
      cos_k_reg     <= 16'sh0000;
      lvl_l_reg     <= 6'h00;
      lvl_r_reg     <= 6'h00;
      x_reg         <= 16'sh0000;
      y_reg         <= 16'sh0000;
      out_l_reg     <= 16'sh0000;
      out_r_reg     <= 16'sh0000;
      valid_reg     <= 1'b0;
    end else begin
      left_ctl_reg  <= left_ctl_next;
      right_ctl_reg <= right_ctl_next;
      len_h_reg     <= len_h_next;
      len_m_reg     <= len_m_next;
      len_l_reg     <= len_l_next;
      sin_h_reg     <= sin_h_next;
      sin_l_reg     <= sin_l_next;
      cos_h_reg     <= cos_h_next;
      cos_l_reg     <= cos_l_next;
      rsvd_reg      <= rsvd_next;
      rdata_reg     <= rdata_next;
      state_reg     <= state_next;
      remain_reg    <= remain_next;
      sin_k_reg     <= sin_k_next;
      cos_k_reg     <= cos_k_next;
      lvl_l_reg     <= lvl_l_next;
      lvl_r_reg     <= lvl_r_next;
      x_reg         <= x_next;
      y_reg         <= y_next;
      out_l_reg     <= out_l_next;
      out_r_reg     <= out_r_next;
      valid_reg     <= valid_next;
    end
  end

  assign reg_rdata_o   = rdata_reg;
  assign beep_left_o   = out_l_reg;
  assign beep_right_o  = out_r_reg;
  assign beep_valid_o  = valid_reg;
  assign beep_active_o = state_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_last_step;
    state_reg == BTG_RUN && left_ctl_reg[BTG_EN_BIT] && sample_tick_i &&
      tone_capable_dac_processing_mode_i && remain_reg == 24'h000001 &&
      !reg_wr_i;
  endsequence
  sequence s_start;
    state_reg == BTG_IDLE && left_ctl_reg[BTG_EN_BIT];
  endsequence

  property p_self_clear;
    s_last_step |=> !left_ctl_reg[BTG_EN_BIT] && state_reg == BTG_IDLE
      ##1 !left_ctl_reg[BTG_EN_BIT] || $past(reg_wr_i);
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("enable did not clear after the last sample");

  property p_start_latch;
    s_start |=> state_reg == BTG_RUN && remain_reg == $past(length) &&
      sin_k_reg == $past({sin_h_reg, sin_l_reg});
  endproperty
  a_start_latch: assert property (p_start_latch)
    else $error("start did not latch length and coefficient");

  property p_count_down;
    state_reg == BTG_RUN && left_ctl_reg[BTG_EN_BIT] && sample_tick_i &&
      tone_capable_dac_processing_mode_i && remain_reg != 24'h000000
      |=> remain_reg == $past(remain_reg) - 24'h000001 && beep_valid_o;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("sample count did not step down by one");

  property p_reset_values;
    !$past(rst_n_i) |-> length == 24'h0000ee &&
      {sin_h_reg, sin_l_reg} == 16'h10d8 &&
      {cos_h_reg, cos_l_reg} == 16'h7ee3;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("length or coefficient reset value wrong");

  property p_link_right_to_left;
    link == BTG_LINK_R2L |-> sel_l == right_ctl_reg[BTG_LVL_MSB:0] &&
      sel_r == right_ctl_reg[BTG_LVL_MSB:0];
  endproperty
  a_link_right_to_left: assert property (p_link_right_to_left)
    else $error("left level does not follow right level");

  property p_link_left_to_right;
    link == BTG_LINK_L2R |-> sel_r == left_ctl_reg[BTG_LVL_MSB:0] &&
      sel_l == left_ctl_reg[BTG_LVL_MSB:0];
  endproperty
  a_link_left_to_right: assert property (p_link_left_to_right)
    else $error("right level does not follow left level");

  property p_link_independent;
    (link == 2'h0 || link == 2'h3) |-> sel_l == left_ctl_reg[5:0] &&
      sel_r == right_ctl_reg[5:0];
  endproperty
  a_link_independent: assert property (p_link_independent)
    else $error("levels not independent");

  property p_gain_top;
    rom_l == 6'h00 |=> gain_l == BTG_GAIN_P2DB;
  endproperty
  a_gain_top: assert property (p_gain_top)
    else $error("code zero is not the +2 dB gain");

  property p_gain_bottom;
    rom_r == 6'h3f |=> gain_r == 16'h000e;
  endproperty
  a_gain_bottom: assert property (p_gain_bottom)
    else $error("all-ones code is not the -61 dB gain");

  property p_mode_silent;
    state_reg == BTG_RUN && left_ctl_reg[BTG_EN_BIT] && sample_tick_i &&
      !tone_capable_dac_processing_mode_i && remain_reg != 24'h000000
      |=> beep_left_o == 16'sh0000 && beep_right_o == 16'sh0000 &&
      remain_reg == $past(remain_reg);
  endproperty
  a_mode_silent: assert property (p_mode_silent)
    else $error("tone produced outside tone-capable mode");

  property p_first_sample;
    s_start ##1 (sample_tick_i && tone_capable_dac_processing_mode_i &&
      remain_reg != 24'h000000 && left_ctl_reg[BTG_EN_BIT])
      |=> y_reg == 16'(($past(sin_k_reg) * 32'sh0000_7fff) >>> BTG_OSC_FRAC)
      && beep_left_o == 16'sh0000;
  endproperty
  a_first_sample: assert property (p_first_sample)
    else $error("oscillator first step wrong");
endmodule

/* File: bench/btg_dac_path_model.sv */
// Model of the DAC playback path: makes word-clock ticks, takes samples.
// Assumes the generator shares its clock and its synchronous reset.
`timescale 1ns/100ps
module btg_dac_path_model #(
  parameter int GAP = 4
) (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               mode_i,
  input  wire logic               valid_i,
  input  wire logic               active_i,
  input  wire logic signed [15:0] left_i,
  input  wire logic signed [15:0] right_i,
  output logic                    tick_o,
  output logic                    mode_o,
  output int                      count_o,
  output logic signed [15:0]      s1_left_o,
  output logic signed [15:0]      s1_right_o
);
  int   gap_reg;
  int   idx_reg;
  logic mode_d;

  // Samples taken while the mode is wrong are zeros and are not counted.
  // The generator saw mode_o one cycle before its valid pulse, so the
  // count uses that delayed copy of the mode.
  always_ff @(posedge ref_clk_i) begin
    mode_o <= mode_i;
    mode_d <= mode_o;
    if (!rst_n_i) begin
      gap_reg    <= 0;
      tick_o     <= 1'b0;
      count_o    <= 0;
      idx_reg    <= 0;
      s1_left_o  <= 16'sh0000;
      s1_right_o <= 16'sh0000;
    end else begin
      gap_reg <= (gap_reg == GAP - 1) ? 0 : gap_reg + 1;
      tick_o  <= (gap_reg == GAP - 1);
      if (!active_i) begin
        idx_reg <= 0;
      end
      if (valid_i && mode_d) begin
        count_o <= count_o + 1;
        idx_reg <= idx_reg + 1;
        if (idx_reg == 1) begin
          s1_left_o  <= left_i;
          s1_right_o <= right_i;
        end
      end
    end
  end
endmodule

/* File: bench/beep_tone_generator_bench.sv */
// Self-checking bench of the beep tone generator core.
// Assumes the DAC path model in its own file beside this one.
`timescale 1ns/100ps
module beep_tone_generator_bench;
  import btg_pkg::*;
  typedef struct {
    logic [1:0]  link;
    logic [5:0]  lc;
    logic [5:0]  rc;
    logic [5:0]  el;
    logic [5:0]  er;
    logic [15:0] sn;
  } btg_row_t;

  logic                ref_clk_i;
  logic                rst_n_i;
  logic                reg_wr_i;
  logic                reg_rd_i;
  logic [6:0]          reg_addr_i;
  logic [7:0]          reg_wdata_i;
  logic                mode_sel;
  logic                tick;
  logic                mode;
  logic [7:0]          reg_rdata_o;
  logic signed [15:0]  beep_left_o;
  logic signed [15:0]  beep_right_o;
  logic                beep_valid_o;
  logic                beep_active_o;
  int                  count;
  logic signed [15:0]  s1_left;
  logic signed [15:0]  s1_right;
  int                  miscompares;
  int                  checks_done;
  int                  cycles;
  logic [7:0]          v;
  int                  n;
  int                  n_end;
  btg_row_t            rows[5];
  logic [6:0]          dflt_a[11];
  logic [7:0]          dflt_v[11];

  btg_core DUT (
    .ref_clk_i                          (ref_clk_i),
    .rst_n_i                            (rst_n_i),
    .reg_wr_i                           (reg_wr_i),
    .reg_rd_i                           (reg_rd_i),
    .reg_addr_i                         (reg_addr_i),
    .reg_wdata_i                        (reg_wdata_i),
    .sample_tick_i                      (tick),
    .tone_capable_dac_processing_mode_i (mode),
    .reg_rdata_o                        (reg_rdata_o),
    .beep_left_o                        (beep_left_o),
    .beep_right_o                       (beep_right_o),
    .beep_valid_o                       (beep_valid_o),
    .beep_active_o                      (beep_active_o)
  );

  btg_dac_path_model #(.GAP(4)) PATH (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .mode_i     (mode_sel),
    .valid_i    (beep_valid_o),
    .active_i   (beep_active_o),
    .left_i     (beep_left_o),
    .right_i    (beep_right_o),
    .tick_o     (tick),
    .mode_o     (mode),
    .count_o    (count),
    .s1_left_o  (s1_left),
    .s1_right_o (s1_right)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp,
                       input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Output scaling may round either way, so a small slack is allowed.
  task automatic near(input logic [15:0] got, input int exp,
                      input string what);
    int d;
    d = $signed(got) - exp;
    checks_done++;
    if (^got === 1'bx || d > 2 || d < -2) begin
      miscompares++;
      $display("BAD %0t %s got %0d exp %0d", $time, what, d + exp, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 d = reg_rdata_o;
  endtask

  task automatic wait_done(output int got);
    int k;
    k = 0;
    while (beep_active_o !== 1'b0 && k < 5000) begin
      @(posedge ref_clk_i);
      k++;
    end
    repeat (4) @(posedge ref_clk_i);
    got = count;
  endtask

  task automatic run_beep(input logic [5:0] lc, output int got);
    int base;
    int k;
    base = count;
    wr(BTG_OFS_LEFT, {2'b10, lc});
    k = 0;
    while (beep_active_o !== 1'b1 && k < 20) begin
      @(posedge ref_clk_i);
      k++;
    end
    wait_done(got);
    got = got - base;
  endtask

  function automatic int gain(input int c);
    int m[6] = '{20626, 18383, 16384, 14602, 13014, 11599};
    return m[c % 6] >> (c / 6);
  endfunction

  initial begin
    rst_n_i     = 1'b0;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    reg_addr_i  = 7'h00;
    reg_wdata_i = 8'h00;
    mode_sel    = 1'b1;
    cycles      = 0;
    dflt_a = '{7'h47, 7'h48, 7'h49, 7'h4a, 7'h4b, 7'h4c, 7'h4d, 7'h4e,
               7'h4f, 7'h50, 7'h46};
    dflt_v = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hee, 8'h10, 8'hd8, 8'h7e,
               8'he3, 8'h00, 8'h00};
    rows = '{'{2'h0, 6'h00, 6'h02, 6'h00, 6'h02, 16'h10d8},
             '{2'h3, 6'h02, 6'h00, 6'h02, 6'h00, 16'h2000},
             '{2'h1, 6'h00, 6'h08, 6'h08, 6'h08, 16'h10d8},
             '{2'h2, 6'h3f, 6'h00, 6'h3f, 6'h3f, 16'h2000},
             '{2'h0, 6'h07, 6'h3f, 6'h07, 6'h3f, 16'h4000}};
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    wr(7'h46, 8'hff);
    for (int i = 0; i < 11; i++) begin
      rd(dflt_a[i], v);
      check({16'h0, v}, {16'h0, dflt_v[i]}, "reset value");
    end
    run_beep(6'h02, n);
    check(24'(n), 24'd238, "default length");
    rd(BTG_OFS_LEFT, v);
    check({23'h0, v[7]}, 24'h0, "enable self clear");
    wr(BTG_OFS_LEN_L, 8'h03);
    for (int i = 0; i < 5; i++) begin
      wr(BTG_OFS_SIN_H, rows[i].sn[15:8]);
      wr(BTG_OFS_SIN_L, rows[i].sn[7:0]);
      wr(BTG_OFS_RIGHT, {rows[i].link, rows[i].rc});
      run_beep(rows[i].lc, n);
      check(24'(n), 24'd3, "row length");
      near(s1_left, (((int'(rows[i].sn) * 32767) >>> 15) *
           gain(int'(rows[i].el))) >>> 14, "left level");
      near(s1_right, (((int'(rows[i].sn) * 32767) >>> 15) *
           gain(int'(rows[i].er))) >>> 14, "right level");
    end
    wr(BTG_OFS_COS_H, 8'h5a);
    rd(BTG_OFS_COS_H, v);
    check({16'h0, v}, 24'h00005a, "cosine high");
    wr(BTG_OFS_RSVD, 8'h00);
    wr(BTG_OFS_LEN_M, 8'h01);
    wr(BTG_OFS_LEN_L, 8'h02);
    run_beep(6'h02, n);
    check(24'(n), 24'd258, "three byte length");
    wr(BTG_OFS_LEN_M, 8'h00);
    wr(BTG_OFS_LEN_L, 8'h04);
    mode_sel <= 1'b0;
    n = count;
    wr(BTG_OFS_LEFT, 8'h82);
    repeat (40) @(posedge ref_clk_i);
    check({23'h0, beep_active_o}, 24'h1, "paused active");
    check({8'h0, beep_left_o}, 24'h0, "paused sample");
    check(24'(count - n), 24'd0, "paused count");
    mode_sel <= 1'b1;
    wait_done(n_end);
    check(24'(n_end - n), 24'h000004, "resumed length");
    wr(BTG_OFS_LEN_L, 8'h40);
    wr(BTG_OFS_LEFT, 8'h82);
    repeat (20) @(posedge ref_clk_i);
    wr(BTG_OFS_LEFT, 8'h02);
    repeat (4) @(posedge ref_clk_i);
    n = count;
    check({23'h0, beep_active_o}, 24'h0, "stopped active");
    check({8'h0, beep_left_o}, 24'h0, "stopped sample");
    repeat (20) @(posedge ref_clk_i);
    check(24'(count - n), 24'h0, "stopped count");
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(BTG_OFS_SIN_H, v);
    check({16'h0, v}, 24'h000010, "second reset sine");
    rd(BTG_OFS_LEN_L, v);
    check({16'h0, v}, 24'h0000ee, "second reset length");
    finish_test();
  end
endmodule
